// file: verilog/bcl_break_ctrl.sv
// Low break control fields with channel B evaluation and break request.
// Holds break_control, the execution count, a sticky status and its mask.
// Assumes the core reports bus cycles as one-cycle pulses on pclk.
// Assumes zero-wait APB: every access phase ends at its first edge.
//
// Chosen here: the register offsets and the APB register port.
`timescale 1ns/1ps
module bcl_break_ctrl
   import bcl_pkg::*;
#(
   parameter int CW = BCL_COUNT_W
) (
   // Clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // APB slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // Core bus cycles
   input  wire bcl_cycle_s  cycle,
   // Break and interrupt
   output logic             user_break,
   output logic             irq
);

   typedef struct packed {
      bcl_ctrl_s            ctrl;
      logic [BCL_IRQ_W-1:0] status;
      logic [BCL_IRQ_W-1:0] mask;
      logic                 a_seen;
      bcl_fetch_e           fetch;
      logic                 brk;
      logic [31:0]          rdata;
   } bcl_state_s;

   bcl_state_s           state_reg;
   bcl_state_s           state_next;
   logic                 setup;
   logic                 access_wr;
   logic                 sel_ctrl;
   logic                 sel_count;
   logic                 sel_status;
   logic                 sel_mask;
   logic                 mapped;
   logic                 ctrl_wr;
   logic                 cnt_wr;
   logic                 mask_wr;
   logic                 rd_status;
   logic [BCL_IRQ_W-1:0] rd_clear;
   logic                 b_cond;
   logic                 b_hit;
   logic                 b_fire;
   logic [CW-1:0]        count;
   logic                 a_break;
   logic                 b_break;
   logic [31:0]          rd_mux;
   logic [BCL_IRQ_W-1:0] irq_src;

   // ==========================================
   // Bus decode
   assign sel_ctrl   = (paddr == BCL_OFS_CTRL);
   assign sel_count  = (paddr == BCL_OFS_COUNT);
   assign sel_status = (paddr == BCL_OFS_STATUS);
   assign sel_mask   = (paddr == BCL_OFS_MASK);
   assign mapped     = sel_ctrl || sel_count || sel_status || sel_mask;
   assign setup      = psel && !penable;
   assign access_wr  = psel && penable && pwrite;
   assign ctrl_wr    = access_wr && sel_ctrl;
   assign cnt_wr     = access_wr && sel_count;
   assign mask_wr    = access_wr && sel_mask;
   assign rd_status  = psel && penable && !pwrite && sel_status;
   // Clear only the flags the reader was shown; an event at the setup edge stays pending
   assign rd_clear   = rd_status ? state_reg.rdata[BCL_IRQ_W-1:0] : BCL_IRQ_RESET;
   assign pready     = 1'b1;
   assign pslverr    = psel && penable && !mapped;

   // ==========================================
   // Channel B condition
   // Data compare only narrows the address match, never widens it
   assign b_cond = cycle.b_addr_match && (!state_reg.ctrl.data_cmp || cycle.b_data_match);
   assign b_hit  = b_cond && (!state_reg.ctrl.seq_sel || state_reg.a_seen);

   bcl_exec_count #(
      .CW (CW)
   ) u_count (
      .pclk    (pclk),
      .presetn (presetn),
      .enable  (state_reg.ctrl.exec_cnt_en),
      .hit     (b_hit),
      .wr_en   (cnt_wr),
      .wr_data (pwdata[CW-1:0]),
      .count   (count),
      .fire    (b_fire)
   );

   // ==========================================
   // Read mux, captured in the setup cycle for zero-wait access
   always_comb begin
      rd_mux = 32'h0000_0000;
      unique case (paddr)
         BCL_OFS_CTRL: begin
            rd_mux[BCL_BIT_DATA_CMP] = state_reg.ctrl.data_cmp;
            rd_mux[BCL_BIT_AFTER]    = state_reg.ctrl.fetch_after;
            rd_mux[BCL_BIT_SEQ]      = state_reg.ctrl.seq_sel;
            rd_mux[BCL_BIT_EXEC_CNT] = state_reg.ctrl.exec_cnt_en;
         end
         BCL_OFS_COUNT:  rd_mux[CW-1:0] = count;
         BCL_OFS_STATUS: rd_mux[BCL_IRQ_W-1:0] = state_reg.status;
         BCL_OFS_MASK:   rd_mux[BCL_IRQ_W-1:0] = state_reg.mask;
         default:        rd_mux = 32'h0000_0000;
      endcase
   end

   // ==========================================
   // Break sequencing and registers
   always_comb begin
      state_next     = state_reg;
      state_next.brk = 1'b0;
      // Channel A breaks alone only in independent mode
      a_break        = cycle.a_match && !state_reg.ctrl.seq_sel;
      b_break        = 1'b0;

      // ==========================================
      // Channel B fetch timing
      unique case (state_reg.fetch)
         BCL_IDLE: begin
            if (b_fire) begin
               if (cycle.b_is_fetch && state_reg.ctrl.fetch_after) begin
                  state_next.fetch = BCL_WAIT_EXEC;
               end else begin
                  b_break = 1'b1;
               end
            end
         end
         BCL_WAIT_EXEC: begin
            // Further matches while waiting merge into the pending break
            if (cycle.exec_done) begin
               b_break          = 1'b1;
               state_next.fetch = BCL_IDLE;
            end
         end
      endcase

      // ==========================================
      // Sequential condition tracking
      if (b_break) begin
         state_next.a_seen = 1'b0;
      end
      if (cycle.a_match && state_reg.ctrl.seq_sel) begin
         state_next.a_seen = 1'b1;
      end
      if (!state_reg.ctrl.seq_sel) begin
         state_next.a_seen = 1'b0;
      end
      state_next.brk = a_break || b_break;

      // ==========================================
      // Read capture and sticky status
      if (setup && !pwrite) begin
         state_next.rdata = rd_mux;
      end
      state_next.status = state_reg.status & ~rd_clear;
      // Set wins over the read clear
      state_next.status[BCL_IRQ_A] = state_next.status[BCL_IRQ_A] | a_break;
      state_next.status[BCL_IRQ_B] = state_next.status[BCL_IRQ_B] | b_break;

      // ==========================================
      // Register writes
      // Only defined bits are stored; unused bits are discarded
      if (ctrl_wr) begin
         state_next.ctrl.data_cmp    = pwdata[BCL_BIT_DATA_CMP];
         state_next.ctrl.fetch_after = pwdata[BCL_BIT_AFTER];
         state_next.ctrl.seq_sel     = pwdata[BCL_BIT_SEQ];
         state_next.ctrl.exec_cnt_en = pwdata[BCL_BIT_EXEC_CNT];
      end
      if (mask_wr) begin
         state_next.mask = pwdata[BCL_IRQ_W-1:0];
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.ctrl   <= bcl_ctrl_s'(4'h0);
         state_reg.status <= BCL_IRQ_RESET;
         state_reg.mask   <= BCL_IRQ_RESET;
         state_reg.a_seen <= 1'b0;
         state_reg.fetch  <= BCL_IDLE;
         state_reg.brk    <= 1'b0;
         state_reg.rdata  <= BCL_CTRL_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   // ==========================================
   // Outputs
   assign prdata     = state_reg.rdata;
   assign user_break = state_reg.brk;

   // ==========================================
   // Interrupt sources, one per status flag
   // A level output: a masked flag raises it as soon as software unmasks it
   for (genvar gi = 0; gi < BCL_IRQ_W; gi++) begin : g_irq
      assign irq_src[gi] = state_reg.status[gi] && state_reg.mask[gi];
   end
   assign irq        = |irq_src;

endmodule

// file: verilog/bcl_pkg.sv
// Shared constants and carriers for the low break control fields.
// Assumes a 32-bit APB register bus and a single pclk domain.
package bcl_pkg;

   // ==========================================
   // Register map (byte addresses)
   localparam logic [7:0] BCL_OFS_CTRL   = 8'h00;
   localparam logic [7:0] BCL_OFS_COUNT  = 8'h04;
   localparam logic [7:0] BCL_OFS_STATUS = 8'h08;
   localparam logic [7:0] BCL_OFS_MASK   = 8'h0C;

   // ==========================================
   // Field positions of break_control
   localparam int BCL_BIT_DATA_CMP  = 7;
   localparam int BCL_BIT_AFTER     = 6;
   localparam int BCL_BIT_SEQ       = 3;
   localparam int BCL_BIT_EXEC_CNT  = 0;
   localparam logic [31:0] BCL_CTRL_WMASK = 32'h0000_00C9;
   localparam logic [31:0] BCL_CTRL_RESET = 32'h0000_0000;

   // ==========================================
   // Execution count field and status layout
   localparam int          BCL_COUNT_W     = 12;
   localparam logic [11:0] BCL_COUNT_RESET = 12'h000;
   localparam logic [11:0] BCL_COUNT_ONE   = 12'h001;
   localparam int          BCL_IRQ_W       = 2;
   localparam int          BCL_IRQ_A       = 0;
   localparam int          BCL_IRQ_B       = 1;
   localparam logic [1:0]  BCL_IRQ_RESET   = 2'h0;

   typedef enum logic {
      BCL_IDLE      = 1'b0,
      BCL_WAIT_EXEC = 1'b1
   } bcl_fetch_e;

   typedef struct packed {
      logic data_cmp;
      logic fetch_after;
      logic seq_sel;
      logic exec_cnt_en;
   } bcl_ctrl_s;

   // Bus cycle report from the core, same clock
   typedef struct packed {
      logic a_match;
      logic b_addr_match;
      logic b_data_match;
      logic b_is_fetch;
      logic exec_done;
   } bcl_cycle_s;

endpackage

// file: verilog/bcl_exec_count.sv
// Execution count register and its countdown for channel B.
// Assumes hit is a one-cycle pulse per qualified channel B match.
`timescale 1ns/1ps
module bcl_exec_count
   import bcl_pkg::*;
#(
   parameter int CW = BCL_COUNT_W
) (
   // Clock and reset
   input  wire logic          pclk,
   input  wire logic          presetn,
   // Control
   input  wire logic          enable,
   input  wire logic          hit,
   input  wire logic          wr_en,
   input  wire logic [CW-1:0] wr_data,
   // Results
   output logic      [CW-1:0] count,
   output logic               fire
);

   typedef struct packed {
      logic [CW-1:0] count;
   } bcl_cnt_s;

   bcl_cnt_s state_reg;
   bcl_cnt_s state_next;

   // ==========================================
   // Countdown
   always_comb begin
      state_next = state_reg;
      fire       = 1'b0;
      if (!enable) begin
         fire = hit;
      end else if (hit) begin
         // Zero never fires, so an unprogrammed count cannot break
         if (state_reg.count == CW'(BCL_COUNT_ONE)) begin
            fire = 1'b1;
         end
         if (state_reg.count != '0) begin
            state_next.count = state_reg.count - CW'(1);
         end
      end
      if (wr_en) begin
         state_next.count = wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg.count <= CW'(BCL_COUNT_RESET);
      end else begin
         state_reg <= state_next;
      end
   end

   assign count = state_reg.count;

endmodule

// file: verification/bcl_monitor.sv
// Checker for the low break control fields, bound to bcl_break_ctrl.
// Assumes one pclk domain and zeros written to unused bits.
`timescale 1ns/1ps
module bcl_monitor
   import bcl_pkg::*;
(
   // Clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // APB
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // Core side
   input wire bcl_cycle_s  cycle,
   input wire logic        user_break,
   input wire logic        irq
);
   // ====================
   // Shadow of the control bits, updated at the same edge as the design
   logic [31:0] ctl_reg;
   wire         acc   = psel & penable;
   wire         ca    = cycle.a_match;
   wire         cb    = cycle.b_addr_match;
   wire         ce    = cycle.exec_done;
   wire         dcmp  = ctl_reg[BCL_BIT_DATA_CMP];
   wire         aft   = ctl_reg[BCL_BIT_AFTER];
   wire         chain = ctl_reg[BCL_BIT_SEQ];
   wire         cnt   = ctl_reg[BCL_BIT_EXEC_CNT];
   always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
         ctl_reg <= '0;
      else if (acc & pwrite & paddr == BCL_OFS_CTRL)
         ctl_reg <= pwdata & BCL_CTRL_WMASK;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   sequence s_read(ofs);
      acc & !pwrite & paddr == ofs;
   endsequence
   sequence s_lone_b;
      cb & !ca & !ce;
   endsequence
   // ====================
   // Assertions
   a_ctrl_readback: assert property (s_read(BCL_OFS_CTRL) |-> prdata == ctl_reg)
      else $error("control readback wrong");
   a_count_width: assert property (s_read(BCL_OFS_COUNT) |-> prdata[31:12] == 20'h0)
      else $error("count upper bits set");
   a_data_ignored: assert property (s_lone_b ##0 (dcmp & !cycle.b_data_match) |=> !user_break)
      else $error("break without data match");
   a_fetch_before: assert property (s_lone_b ##0 (!aft & !chain & !cnt & (!dcmp | cycle.b_data_match))
      |=> user_break)
      else $error("missing early break");
   a_fetch_after: assert property (s_lone_b ##0 (aft & cycle.b_is_fetch) |=> !user_break)
      else $error("fetch break too early");
   a_chan_a_alone: assert property (ca & !chain |=> user_break)
      else $error("missing channel A break");
   a_seq_a_quiet: assert property (ca & chain & !cb & !ce |=> !user_break)
      else $error("channel A broke in sequence");
   a_break_cause: assert property (user_break |-> $past(ca | cb | ce))
      else $error("break without cause");
endmodule
bind bcl_break_ctrl bcl_monitor bcl_monitor_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
   .prdata, .pready, .pslverr, .cycle, .user_break, .irq);

// file: verification/bcl_core_model.sv
// Behavioural core reporting bus cycles to the break logic.
// Assumes one requested cycle at a time; a fetch completes later.
`timescale 1ns/1ps
module bcl_core_model
   import bcl_pkg::*;
(
   // Clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // Request from the bench
   input  wire logic       go,
   input  wire bcl_cycle_s req,
   input  wire logic [3:0] lat,
   // Reported bus cycle
   output bcl_cycle_s      cycle
);
   // Latency varies so prompt and slow completions both occur
   logic [4:0] left_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle    <= '0;
         left_reg <= '0;
      end else begin
         cycle           <= go ? req : '0;
         cycle.exec_done <= (left_reg == 5'h1);
         if (go & req.b_is_fetch & req.b_addr_match)
            left_reg <= {1'b0, lat} + 5'h1;
         else if (left_reg != 5'h0)
            left_reg <= left_reg - 5'h1;
      end
   end
endmodule

// file: verification/testbench.sv
// Self-checking bench for bcl_break_ctrl with a core bus model.
// Assumes zero-wait APB and bus cycles reported on pclk.
`timescale 1ns/1ps
module testbench
   import bcl_pkg::*;
   ;
   logic        pclk, presetn, psel, penable, pwrite, go, pready, pslverr, user_break, irq;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  lat;
   bcl_cycle_s  req, cycle;
   int          miscompares, samples_checked, brk, b0, m_cnt, m_seen, m_a, m_b;
   logic [7:0]  tc [12] = '{8'h0, 8'h80, 8'h80, 8'h40, 8'h40, 8'h8, 8'h8, 8'h8, 8'h0, 8'h1, 8'h1, 8'h1};
   bcl_cycle_s  tr [12] = '{5'hA, 5'h8, 5'hC, 5'hA, 5'h8, 5'h10, 5'h8, 5'h8, 5'h10, 5'h8, 5'h8, 5'h8};
   bcl_break_ctrl bcl_break_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
      .pready, .pslverr, .cycle, .user_break, .irq);
   bcl_core_model bcl_core_model_i (.pclk, .presetn, .go, .req, .lat, .cycle);
   // ====================
   // Clock and break counting
   always #2.5 pclk = ~pclk;
   always @(posedge pclk) if (user_break === 1'b1) brk++;
   task automatic test_done;
      if (miscompares == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      samples_checked++;
      if (s !== e) begin
         miscompares++;
         $display("Error %0t seen %h expected %h", $time, s, e);
      end
   endtask
   // Read data and pready are taken at the edge that ends the access
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e);
      int n;
      n = 0;
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         miscompares++;
         test_done();
      end else begin
         chk(pslverr, a > BCL_OFS_MASK);
         if (!w) chk(prdata, e);
         psel    <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task automatic core(input bcl_cycle_s r);
      go  <= 1'b1;
      req <= r;
      lat <= 4'($urandom % 8);
      @(posedge pclk);
      go <= 1'b0;
      repeat (14) @(posedge pclk);
   endtask
   // Reference model of one core cycle against the control bits, in plain integers
   task automatic model(input logic [7:0] c, input bcl_cycle_s r);
      int hit;
      hit = r.b_addr_match && (!c[BCL_BIT_DATA_CMP] || r.b_data_match) && (!c[BCL_BIT_SEQ] || m_seen != 0);
      m_a = r.a_match && !c[BCL_BIT_SEQ];
      m_b = hit && (!c[BCL_BIT_EXEC_CNT] || m_cnt == 1);
      if (hit && c[BCL_BIT_EXEC_CNT] && m_cnt > 0) m_cnt--;
      if (!c[BCL_BIT_SEQ]) m_seen = 0;
      else if (r.a_match) m_seen = 1;
      else if (m_b != 0) m_seen = 0;
   endtask
   // ====================
   // Main sequence
   initial begin
      logic [31:0] r;
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, go, paddr, pwdata, lat, req} = '0;
      void'($urandom(15));
      repeat (10) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, BCL_OFS_CTRL, 32'h0, 32'h0);
      apb(1'b0, BCL_OFS_COUNT, 32'h0, 32'h0);
      repeat (8) begin
         r = $urandom & BCL_CTRL_WMASK;
         apb(1'b1, BCL_OFS_CTRL, r, 32'h0);
         apb(1'b0, BCL_OFS_CTRL, 32'h0, r);
      end
      apb(1'b1, BCL_OFS_COUNT, 32'hFFF, 32'h0);
      m_cnt = 'hFFF;
      apb(1'b0, BCL_OFS_COUNT, 32'h0, 32'hFFF);
      apb(1'b0, 8'h10, 32'h0, 32'h0);
      apb(1'b1, BCL_OFS_MASK, 32'h2, 32'h0);
      for (int i = 0; i < 12; i++) begin
         if (i == 9) begin
            apb(1'b1, BCL_OFS_COUNT, 32'h2, 32'h0);
            m_cnt = 2;
         end
         apb(1'b1, BCL_OFS_CTRL, {24'h0, tc[i]}, 32'h0);
         b0 = brk;
         core(tr[i]);
         model(tc[i], tr[i]);
         if (i == 9) apb(1'b0, BCL_OFS_COUNT, 32'h0, m_cnt);
         chk(brk - b0, m_a | m_b);
         // Only channel B is unmasked
         chk(irq, m_b);
         apb(1'b0, BCL_OFS_STATUS, 32'h0, (m_b << BCL_IRQ_B) | (m_a << BCL_IRQ_A));
         chk(irq, 1'b0);
      end
      test_done();
   end
endmodule
